// >>> rtl/hbr_pkg.sv
/*
  Shared constants and types for the dual H-bridge regulation and fault
  controller. Assumes a single 40 MHz device clock.
*/
package hbr_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 25;

  // Durations in their own unit
  localparam int OFF_TIME_NS          = 20000;    // Nominal forced off-time
  localparam int OC_BLANK_TIME_NS     = 2000;     // Overcurrent blanking
  localparam int OC_RETRY_TIME_NS     = 3000000;  // Retry period, 3 ms

  // Cycle counts: off-time and retry round down, blanking rounds up
  localparam int OFF_CYCLES      = OFF_TIME_NS / CLK_PERIOD_NS;
  localparam int OC_BLANK_CYCLES = (OC_BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_RETRY_CYCLES = OC_RETRY_TIME_NS / CLK_PERIOD_NS;

  // Counter width, large enough for the retry count
  localparam int CNT_W = 17;

  // Fast share of the off-time for mixed decay, percent
  localparam int MIX_LOW_FAST_PCT  = 30;
  localparam int MIX_HIGH_FAST_PCT = 60;
  localparam int PCT_FULL          = 100;

  // Number of bridges
  localparam int NUM_BRIDGES = 2;

  // Width of the pin vector
  localparam int PIN_W = 14;

  // Decay selection, upper pin then lower pin
  typedef enum logic [1:0] {
    HBR_DECAY_SLOW  = 2'b00,
    HBR_DECAY_MIX30 = 2'b01,
    HBR_DECAY_MIX60 = 2'b10,
    HBR_DECAY_FAST  = 2'b11
  } hbr_decay_e;

  // Per-bridge regulation state
  typedef enum logic [1:0] {
    HBR_ST_NORMAL = 2'b00,
    HBR_ST_DECAY  = 2'b01,
    HBR_ST_RETRY  = 2'b10
  } hbr_state_e;

  // Gate drive of one bridge; both switches of a half off means high impedance
  typedef struct packed {
    logic first_hs;
    logic first_ls;
    logic second_hs;
    logic second_ls;
  } hbr_gate_s;

  // Controller inputs of one bridge
  typedef struct packed {
    logic enable;
    logic drive_in_first;
    logic drive_in_second;
  } hbr_ctrl_s;

  // Analog comparator flags of one bridge
  typedef struct packed {
    logic regulation_threshold;
    logic overcurrent_protect;
  } hbr_sense_s;

  // Gate value with the bridge high impedance
  localparam hbr_gate_s GATE_HIZ = 4'h0;

endpackage : hbr_pkg

// >>> rtl/hbr_ctrl.sv
/*
  Regulation, decay selection and fault handling of a dual H-bridge driver.
  Holds the pin filter, the per-bridge off-time, blanking and retry timers,
  the gate selection of both bridges and the registered open-drain enables
  of the regulation activity and fault pins.
  Assumes all pin and comparator inputs are asynchronous to mclk_i; the
  open-drain outputs are resolved to a wire by the surroundings.
  Assumes the gate outputs feed a predriver that adds its own dead time,
  and that the comparator flags are levels, high while above threshold.
*/
`timescale 1ns/10ps

// Function
// - Regulation output held low for the whole forced off-time decay.
// - Decays chosen by the controller's own inputs never assert regulation output.
// - During forced off-time the loop overrides both direction inputs.
// - Entering forced decay and every fresh trip during it restart the off-time timer.
// - Decay pins select slow, mixed 30/70, mixed 60/40 or fast decay.
// - Overcurrent counts only if its flag stays high beyond the blanking time.
// - Overcurrent disables that bridge at once and asserts fault.
// - Bridge held off for the retry period, then re-enabled from inputs.
// - Thermal shutdown tri-states all outputs and holds fault low until cleared.
// - Supply lockout tri-states all outputs and holds fault low until cleared.
// - Enable low gives high impedance outside forced decay; otherwise direction inputs pick the drive.
// - Trip threshold crossing enforces decay for the off-time, then resumes drive.
module hbr_ctrl #(
  parameter int OFF_CYCLES      = hbr_pkg::OFF_CYCLES,
  parameter int OC_BLANK_CYCLES = hbr_pkg::OC_BLANK_CYCLES,
  parameter int OC_RETRY_CYCLES = hbr_pkg::OC_RETRY_CYCLES
) (
  input  wire logic                                      mclk_i,
  input  wire logic                                      rst_n_i,
  input  wire hbr_pkg::hbr_ctrl_s  [hbr_pkg::NUM_BRIDGES-1:0] bridge_ctrl_i,
  input  wire hbr_pkg::hbr_sense_s [hbr_pkg::NUM_BRIDGES-1:0] bridge_sense_i,
  input  wire logic                                      decay_sel_hi_i,
  input  wire logic                                      decay_sel_lo_i,
  input  wire logic                                      thermal_shutdown_i,
  input  wire logic                                      supply_low_lockout_i,
  output hbr_pkg::hbr_gate_s       [hbr_pkg::NUM_BRIDGES-1:0] bridge_gate_o,
  output logic                     [hbr_pkg::NUM_BRIDGES-1:0] regulation_active_n_o,
  output logic                     [hbr_pkg::NUM_BRIDGES-1:0] regulation_active_n_oe_o,
  output logic                                           fault_n_o,
  output logic                                           fault_n_oe_o
);

  // Short names for the package sizes
  localparam int NB = hbr_pkg::NUM_BRIDGES;
  localparam int PW = hbr_pkg::PIN_W;
  localparam int CW = hbr_pkg::CNT_W;

  // Drive one bridge: high input turns on high side, low input the low side;
  // never both switches of one half, so this logic cannot cause shoot-through
  function automatic hbr_pkg::hbr_gate_s half_drive(input logic first_high,
                                                    input logic second_high);
    hbr_pkg::hbr_gate_s g;
    g.first_hs  = first_high;
    g.first_ls  = ~first_high;
    g.second_hs = second_high;
    g.second_ls = ~second_high;
    return g;
  endfunction : half_drive

  // Off-time gate pattern: reversed drive while fast, both low sides while slow
  function automatic hbr_pkg::hbr_gate_s decay_drive(input logic fast,
                                                     input logic fwd);
    hbr_pkg::hbr_gate_s g;
    if (fast) begin
      g = half_drive(fwd, ~fwd);
    end else begin
      g = half_drive(1'b0, 1'b0);
    end
    return g;
  endfunction : decay_drive

  // Cycles of fast decay at the start of the off-time; rounded down, so a
  // very short off-time can lose its fast share entirely
  function automatic logic [CW-1:0] fast_share(input hbr_pkg::hbr_decay_e mode);
    logic [CW-1:0] r;
    r = '0;
    unique case (mode)
      hbr_pkg::HBR_DECAY_SLOW:  r = '0;
      hbr_pkg::HBR_DECAY_MIX30:
        r = CW'((OFF_CYCLES * hbr_pkg::MIX_LOW_FAST_PCT) / hbr_pkg::PCT_FULL);
      hbr_pkg::HBR_DECAY_MIX60:
        r = CW'((OFF_CYCLES * hbr_pkg::MIX_HIGH_FAST_PCT) / hbr_pkg::PCT_FULL);
      hbr_pkg::HBR_DECAY_FAST:  r = CW'(OFF_CYCLES);
    endcase
    return r;
  endfunction : fast_share

  // Pin synchroniser, three stages, filtered when stages two and three agree;
  // a one-sample glitch never reaches the loop, at the cost of four cycles
  // of latency on every pin and comparator flag
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] sync1_reg;
  logic [PW-1:0] sync2_reg;
  logic [PW-1:0] sync3_reg;
  logic [PW-1:0] pin_reg;

  assign pin_raw = {bridge_ctrl_i, bridge_sense_i, decay_sel_hi_i, decay_sel_lo_i,
                    thermal_shutdown_i, supply_low_lockout_i};

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      pin_reg   <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg   <= (sync2_reg & sync3_reg) | (pin_reg & (sync2_reg ^ sync3_reg));
    end
  end

  // Filtered pin view
  // Field order follows the concatenation into pin_raw above
  hbr_pkg::hbr_ctrl_s  [NB-1:0] ctrl;
  hbr_pkg::hbr_sense_s [NB-1:0] sense;
  hbr_pkg::hbr_decay_e          decay_mode;
  logic                         therm_flag;
  logic                         supply_flag;
  logic                         lockout;

  assign {ctrl, sense} = pin_reg[PW-1:4];
  assign decay_mode    = hbr_pkg::hbr_decay_e'(pin_reg[3:2]);
  assign therm_flag    = pin_reg[1];
  assign supply_flag   = pin_reg[0];
  assign lockout       = therm_flag | supply_flag;

  // Per-bridge summaries that feed the shared pins
  logic [NB-1:0] retry_next;
  logic [NB-1:0] decay_next;

  for (genvar b = 0; b < NB; b++) begin : g_bridge

    // Registers and next values of this bridge
    hbr_pkg::hbr_state_e state_reg;
    hbr_pkg::hbr_state_e state_next;
    logic [CW-1:0]       cnt_reg;
    logic [CW-1:0]       cnt_next;
    logic [CW-1:0]       blank_reg;
    logic                trip_d_reg;
    logic                fwd_reg;
    logic                fwd_next;
    logic                driving;
    logic                trip_rise;
    logic                oc_event;
    logic                fast_phase;
    hbr_pkg::hbr_gate_s  gate_next;

    // Only a forward or reverse pattern can build current past the trip point
    assign driving   = ctrl[b].enable & (ctrl[b].drive_in_first ^ ctrl[b].drive_in_second);
    assign trip_rise = sense[b].regulation_threshold & ~trip_d_reg;

    // Blanking: flag must stay high for more than the blanking count;
    // the counter saturates so a long short cannot wrap it
    assign oc_event = sense[b].overcurrent_protect &&
                      (blank_reg == CW'(OC_BLANK_CYCLES));

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        blank_reg <= '0;
      end else if (!sense[b].overcurrent_protect || state_next == hbr_pkg::HBR_ST_RETRY) begin
        blank_reg <= '0;
      end else if (blank_reg != CW'(OC_BLANK_CYCLES)) begin
        blank_reg <= blank_reg + 1'b1;
      end
    end

    // Trip edge detector on the filtered comparator flag; it starts at the
    // idle level of the flag, so leaving reset makes no false edge
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        trip_d_reg <= 1'b0;
      end else begin
        trip_d_reg <= sense[b].regulation_threshold;
      end
    end

    // Regulation and retry sequencing. A trip still high when the off-time
    // ends starts no new decay: the loop waits for a fresh rising edge, so a
    // stuck comparator cannot hold the bridge in decay forever
    always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      fwd_next   = fwd_reg;
      // Shutdown and lockout win over all and drop any pending retry
      if (lockout) begin
        state_next = hbr_pkg::HBR_ST_NORMAL;
        cnt_next   = '0;
      end else begin
        unique case (state_reg)
          // Normal: follow the pins, watch for a short or a trip
          hbr_pkg::HBR_ST_NORMAL: begin
            if (oc_event) begin
              state_next = hbr_pkg::HBR_ST_RETRY;
              cnt_next   = CW'(OC_RETRY_CYCLES - 1);
            end else if (trip_rise && driving) begin
              state_next = hbr_pkg::HBR_ST_DECAY;
              cnt_next   = CW'(OFF_CYCLES - 1);
              fwd_next   = ctrl[b].drive_in_second;
            end
          end
          // Decay: the loop owns the bridge until the count runs out
          hbr_pkg::HBR_ST_DECAY: begin
            if (oc_event) begin
              state_next = hbr_pkg::HBR_ST_RETRY;
              cnt_next   = CW'(OC_RETRY_CYCLES - 1);
            end else if (trip_rise) begin
              cnt_next = CW'(OFF_CYCLES - 1);
            end else if (cnt_reg == '0) begin
              state_next = hbr_pkg::HBR_ST_NORMAL;
            end else begin
              cnt_next = cnt_reg - 1'b1;
            end
          end
          // Retry: bridge off for the whole retry period
          hbr_pkg::HBR_ST_RETRY: begin
            if (cnt_reg == '0) begin
              state_next = hbr_pkg::HBR_ST_NORMAL;
            end else begin
              cnt_next = cnt_reg - 1'b1;
            end
          end
          // Unused code: fall back to normal with the counter cleared
          default: begin
            state_next = hbr_pkg::HBR_ST_NORMAL;
            cnt_next   = '0;
          end
        endcase
      end
    end

    // Fast portion runs first, the rest of the off-time is slow decay
    assign fast_phase = (CW'(OFF_CYCLES - 1) - cnt_next) < fast_share(decay_mode);

    // Gate selection; the loop ignores direction inputs while decaying
    always_comb begin
      gate_next = hbr_pkg::GATE_HIZ;
      if (lockout || state_next == hbr_pkg::HBR_ST_RETRY) begin
        gate_next = hbr_pkg::GATE_HIZ;
      end else if (state_next == hbr_pkg::HBR_ST_DECAY) begin
        gate_next = decay_drive(fast_phase, fwd_next);
      end else if (ctrl[b].enable) begin
        gate_next = half_drive(ctrl[b].drive_in_first, ctrl[b].drive_in_second);
      end
    end

    // Next-state flags, so the shared pins move with the gates
    assign retry_next[b] = (state_next == hbr_pkg::HBR_ST_RETRY);
    assign decay_next[b] = (state_next == hbr_pkg::HBR_ST_DECAY);

    // State, counter and direction registers; the direction is kept so
    // fast decay reverses the current that was flowing at the trip
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        state_reg <= hbr_pkg::HBR_ST_NORMAL;
        cnt_reg   <= '0;
        fwd_reg   <= 1'b0;
      end else begin
        state_reg <= state_next;
        cnt_reg   <= cnt_next;
        fwd_reg   <= fwd_next;
      end
    end

    // Registered gate drive, off at reset so the bridge starts high impedance;
    // the register costs a cycle but keeps decode glitches off the predriver
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        bridge_gate_o[b] <= hbr_pkg::GATE_HIZ;
      end else begin
        bridge_gate_o[b] <= gate_next;
      end
    end

  end : g_bridge

  // Regulation activity pins; only loop-forced decay pulls them low
  // Level and enable come from one register stage, so they never disagree
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      regulation_active_n_o    <= '1;
      regulation_active_n_oe_o <= '0;
    end else begin
      regulation_active_n_o    <= ~decay_next;
      regulation_active_n_oe_o <= decay_next;
    end
  end

  // Fault pin is a level, low while any fault condition holds
  // Thermal and supply flags cover both bridges, overcurrent only its own
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_n_o    <= 1'b1;
      fault_n_oe_o <= 1'b0;
    end else begin
      fault_n_o    <= ~((|retry_next) | lockout);
      fault_n_oe_o <= (|retry_next) | lockout;
    end
  end

endmodule : hbr_ctrl

// >>> test/hbr_ctrl_asserts.sv
/* Port checker for hbr_ctrl.
   Assumes the bench never overlaps faults with a forced decay. */
`timescale 1ns/10ps
module hbr_ctrl_chk #(
  parameter int OFF_CYCLES = hbr_pkg::OFF_CYCLES
) (
  input wire logic                                      mclk_i,
  input wire logic                                      rst_n_i,
  input wire hbr_pkg::hbr_ctrl_s  [hbr_pkg::NUM_BRIDGES-1:0] bridge_ctrl_i,
  input wire hbr_pkg::hbr_sense_s [hbr_pkg::NUM_BRIDGES-1:0] bridge_sense_i,
  input wire logic                                      thermal_shutdown_i,
  input wire logic                                      supply_low_lockout_i,
  input wire hbr_pkg::hbr_gate_s  [hbr_pkg::NUM_BRIDGES-1:0] bridge_gate_o,
  input wire logic                [hbr_pkg::NUM_BRIDGES-1:0] regulation_active_n_o,
  input wire logic                [hbr_pkg::NUM_BRIDGES-1:0] regulation_active_n_oe_o,
  input wire logic                                      fault_n_o,
  input wire logic                                      fault_n_oe_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  int   low_cnt;
  int   quiet;
  logic fwd_ok;
  logic any_flt;
  assign fwd_ok = bridge_ctrl_i[0].enable && !bridge_ctrl_i[0].drive_in_first
    && bridge_ctrl_i[0].drive_in_second && !thermal_shutdown_i && !supply_low_lockout_i;
  assign any_flt = bridge_sense_i[0].overcurrent_protect || bridge_sense_i[1].overcurrent_protect
    || thermal_shutdown_i || supply_low_lockout_i;
  // Length of the present decay, and quiet time since the last trip
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt <= 0;
      quiet <= 0;
    end else begin
      low_cnt <= regulation_active_n_o[0] ? 0 : low_cnt + 1;
      quiet <= bridge_sense_i[0].regulation_threshold ? 0 : quiet + 1;
    end
  end
  chk_fault_oe_pair: assert property (fault_n_oe_o == !fault_n_o)
    else $error("fault enable disagrees with level");
  chk_reg_oe_pair: assert property (regulation_active_n_oe_o == ~regulation_active_n_o)
    else $error("regulation enable disagrees with level");
  chk_thermal_hiz: assert property (thermal_shutdown_i [*7] |-> bridge_gate_o == '0 && !fault_n_o)
    else $error("thermal fault not off");
  chk_supply_hiz: assert property (supply_low_lockout_i [*7] |-> bridge_gate_o == '0 && !fault_n_o)
    else $error("supply fault not off");
  chk_disabled_hiz: assert property ((!bridge_ctrl_i[0].enable) [*7] ##0 regulation_active_n_o[0]
    |-> bridge_gate_o[0] == hbr_pkg::GATE_HIZ) else $error("disabled bridge driven");
  chk_forward_drive: assert property (fwd_ok [*7] ##0 (regulation_active_n_o[0] && fault_n_o)
    |-> bridge_gate_o[0] == 4'h6) else $error("forward drive wrong");
  chk_decay_min: assert property ($rose(regulation_active_n_o[0]) |-> low_cnt >= OFF_CYCLES)
    else $error("decay ended early");
  chk_decay_bound: assert property (quiet > OFF_CYCLES + 8 |-> regulation_active_n_o[0])
    else $error("decay outlived its trip");
  chk_fault_cause: assert property ($fell(fault_n_o)
    |-> $past(any_flt, 3) || $past(any_flt, 4) || $past(any_flt, 5)) else $error("fault without cause");
endmodule : hbr_ctrl_chk

bind hbr_ctrl hbr_ctrl_chk #(.OFF_CYCLES(OFF_CYCLES)) hbr_ctrl_chk_inst (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bridge_ctrl_i(bridge_ctrl_i),
  .bridge_sense_i(bridge_sense_i), .thermal_shutdown_i(thermal_shutdown_i),
  .supply_low_lockout_i(supply_low_lockout_i), .bridge_gate_o(bridge_gate_o),
  .regulation_active_n_o(regulation_active_n_o),
  .regulation_active_n_oe_o(regulation_active_n_oe_o),
  .fault_n_o(fault_n_o), .fault_n_oe_o(fault_n_oe_o));

// >>> test/hbr_pull_model.sv
/* Controller side of the open-drain lines: pull-ups to its supply.
   Assumes an enable is high while the block pulls a line low. */
`timescale 1ns/10ps
module hbr_pull_model (
  input  wire logic [1:0] reg_n_i,
  input  wire logic [1:0] reg_oe_i,
  input  wire logic       fault_n_i,
  input  wire logic       fault_oe_i,
  output logic      [1:0] reg_pin_o,
  output logic            fault_pin_o
);
  // Released lines rise to the pull-up, never keep the last value
  assign reg_pin_o = (reg_oe_i & reg_n_i) | ~reg_oe_i;
  assign fault_pin_o = fault_oe_i ? fault_n_i : 1'b1;
endmodule : hbr_pull_model

// >>> test/testbench.sv
/* Pin-level bench for hbr_ctrl: drive table, decay, faults.
   Assumes shortened off-time, blanking and retry counts. */
`timescale 1ns/10ps
module testbench;
  localparam int OFF = 20;
  localparam int BLK = 4;
  localparam int RTY = 50;
  logic                     mclk_i;
  logic                     rst_n_i;
  hbr_pkg::hbr_ctrl_s  [1:0] ctrl;
  hbr_pkg::hbr_sense_s [1:0] sense;
  logic                     dhi, dlo, ts, uv, fn, foe, fpin;
  hbr_pkg::hbr_gate_s  [1:0] gate;
  logic                [1:0] rn, roe, rpin;
  int                       num_errors = 0;
  int                       compares = 0;
  int                       cyc = 0;
  int                       tot, fast;
  const logic [3:0] dir_exp [4] = '{4'h5, 4'h6, 4'h9, 4'hA};
  const int pct [4] = '{0, 30, 60, 100};
  hbr_ctrl #(.OFF_CYCLES(OFF), .OC_BLANK_CYCLES(BLK), .OC_RETRY_CYCLES(RTY)) hbr_ctrl_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bridge_ctrl_i(ctrl), .bridge_sense_i(sense),
    .decay_sel_hi_i(dhi), .decay_sel_lo_i(dlo), .thermal_shutdown_i(ts),
    .supply_low_lockout_i(uv), .bridge_gate_o(gate), .regulation_active_n_o(rn),
    .regulation_active_n_oe_o(roe), .fault_n_o(fn), .fault_n_oe_o(foe));
  hbr_pull_model hbr_pull_model_inst (.reg_n_i(rn), .reg_oe_i(roe), .fault_n_i(fn),
    .fault_oe_i(foe), .reg_pin_o(rpin), .fault_pin_o(fpin));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : wait_n
  task automatic drive(input logic en, input logic d1, input logic d2);
    ctrl[0] = {en, d1, d2};
    wait_n(8);
  endtask : drive
  // Trip pulse, optional second pulse gap cycles later; time the decay
  task automatic decay(input int b, input int gap, input logic [3:0] fpat,
                       output int t, output int f);
    t = 0;
    f = 0;
    sense[b].regulation_threshold = 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(negedge mclk_i);
      sense[b].regulation_threshold = (i < 3) || (gap > 0 && i >= gap && i < gap + 3);
      if (rpin[b] === 1'b0) t++;
      if (gate[b] === fpat) f++;
      if (t > 0 && rpin[b] === 1'b1) break;
    end
  endtask : decay
  task automatic test_done();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // Free-running 40 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // Cycle ceiling cuts a hang short
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      test_done();
    end
  end
  // Main sequence, inputs changed on falling edges
  initial begin
    rst_n_i = 1'b0;
    ctrl = '0;
    sense = '0;
    {dhi, dlo, ts, uv} = 4'h0;
    wait_n(3);
    chk("reset gate", 8'(gate), 8'h00);
    chk("reset fault", 8'(fpin), 8'h01);
    rst_n_i = 1'b1;
    drive(0, 0, 1);
    chk("off gate", 8'(gate[0]), 8'h00);
    for (int k = 0; k < 4; k++) begin
      drive(1, k[1], k[0]);
      chk("drive gate", 8'(gate[0]), 8'(dir_exp[k]));
      chk("drive reg", 8'(rpin), 8'h03);
    end
    decay(0, 0, 4'h9, tot, fast);
    chk("brake trip", 8'(tot), 8'h00);
    $display("drive test done");
    drive(1, 0, 1);
    for (int m = 0; m < 4; m++) begin
      {dhi, dlo} = m[1:0];
      wait_n(8);
      decay(0, 0, 4'h9, tot, fast);
      chk("decay len", 8'(tot), 8'(OFF));
      chk("decay fast", 8'(fast), 8'(OFF * pct[m] / 100));
      chk("resume gate", 8'(gate[0]), 8'h06);
    end
    {dhi, dlo} = 2'b00;
    decay(0, 10, 4'h9, tot, fast);
    chk("restart len", 8'(tot), 8'(OFF + 11));
    chk("slow override", 8'(fast), 8'h00);
    $display("decay test done");
    sense[0].overcurrent_protect = 1'b1;
    wait_n(BLK - 1);
    sense[0].overcurrent_protect = 1'b0;
    wait_n(12);
    chk("short oc", 8'(fpin), 8'h01);
    sense[0].overcurrent_protect = 1'b1;
    tot = 0;
    while (fpin !== 1'b0 && tot < 40) begin
      wait_n(1);
      tot++;
    end
    chk("oc late", 8'(tot > BLK), 8'h01);
    chk("oc gate", 8'(gate[0]), 8'h00);
    sense[0].overcurrent_protect = 1'b0;
    tot = 0;
    while (fpin === 1'b0 && tot < 200) begin
      wait_n(1);
      tot++;
    end
    chk("retry len", 8'(tot), 8'(RTY));
    chk("retry gate", 8'(gate[0]), 8'h06);
    $display("overcurrent test done");
    for (int f = 0; f < 2; f++) begin
      {ts, uv} = f ? 2'b01 : 2'b10;
      wait_n(8);
      chk("fault gate", 8'(gate), 8'h00);
      chk("fault pin", 8'(fpin), 8'h00);
      {ts, uv} = 2'b00;
      wait_n(8);
      chk("clear gate", 8'(gate[0]), 8'h06);
      chk("clear pin", 8'(fpin), 8'h01);
    end
    $display("shutdown test done");
    // Second bridge: reverse drive, fast decay, then a short of its own
    ctrl[1] = {1'b1, 1'b1, 1'b0};
    {dhi, dlo} = 2'b11;
    wait_n(8);
    chk("b drive gate", 8'(gate[1]), 8'h09);
    decay(1, 0, 4'h6, tot, fast);
    chk("b decay len", 8'(tot), 8'(OFF));
    chk("b fast reverse", 8'(fast), 8'(OFF));
    chk("b a gate", 8'(gate[0]), 8'h06);
    sense[1].overcurrent_protect = 1'b1;
    wait_n(16);
    chk("b oc gates", 8'(gate), 8'h06);
    chk("b oc pin", 8'(fpin), 8'h00);
    sense[1].overcurrent_protect = 1'b0;
    wait_n(RTY + 8);
    chk("b retry gate", 8'(gate[1]), 8'h09);
    chk("b retry pin", 8'(fpin), 8'h01);
    $display("bridge b test done");
    test_done();
  end
endmodule : testbench
